// ---- dv/qsfls_props.sv ----
`timescale 1ns/1ps
module qsfls_props (
   // system
   input wire logic clk,
   input wire logic reset,
   // link wires
   input wire logic serial_clock_in,
   input wire logic chip_select_n,
   input wire logic lane2,
   input wire logic lane3,
   // device drivers
   input wire logic lane2_dev_o,
   input wire logic lane2_dev_oe,
   input wire logic lane3_dev_o,
   input wire logic lane3_dev_oe,
   // host drivers
   input wire logic lane2_host_o,
   input wire logic lane2_host_oe,
   input wire logic lane3_host_oe
);
   // one domain, so clock and disable are given once
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   // six cycles allow for the device sampler latency
   a_desel_tristate: assert property (
      chip_select_n [*6] |-> !lane2_dev_oe && !lane3_dev_oe)
      else $error("device drives while deselected");
   a_drive_selected: assert property (
      $rose(lane2_dev_oe) |-> !chip_select_n)
      else $error("device drive starts outside a frame");
   // read data moves only a sampler delay after a serial clock fall
   a_lane2_falling: assert property (
      lane2_dev_oe && $past(lane2_dev_oe) && $changed(lane2_dev_o)
      |-> $past(serial_clock_in, 5) && !$past(serial_clock_in, 4))
      else $error("lane two read data moved on a rising half");
   a_lane3_falling: assert property (
      lane3_dev_oe && $past(lane3_dev_oe) && $changed(lane3_dev_o)
      |-> $past(serial_clock_in, 5) && !$past(serial_clock_in, 4))
      else $error("lane three read data moved on a rising half");
   a_host_falling: assert property (
      lane2_host_oe && $past(lane2_host_oe) && $changed(lane2_host_o)
      |-> !serial_clock_in)
      else $error("write data moved while serial clock high");
   a_no_contend: assert property (
      !(lane2_dev_oe && lane2_host_oe) && !(lane3_dev_oe && lane3_host_oe))
      else $error("both ends drive an upper lane");
   // half period is four system clocks
   a_sclk_rate: assert property (
      $changed(serial_clock_in) |=> $stable(serial_clock_in) [*3])
      else $error("serial clock half period too short");
   a_sclk_parked: assert property (
      chip_select_n && $past(chip_select_n) |-> !serial_clock_in)
      else $error("serial clock runs between frames");
   a_idle_pullup: assert property (
      chip_select_n [*6] |-> lane2 && lane3)
      else $error("upper lanes not high between frames");
endmodule : qsfls_props

// ---- dv/qsfls_test.sv ----
`timescale 1ns/1ps
module qsfls_test;
   logic                     clk, reset, start, busy, done, hi;
   logic                     rx_valid, armed, dv2_valid, dv2_armed, bad2;
   logic [7:0]               h0, h2, h3, d2, d3, hrx2, hrx3;
   logic [7:0]               drx0, drx2, drx3, r0, r2, r3;
   qsfls_pkg::qsfls_dir_type hdir, ddir;
   int                       error_cnt, n_tests;

   // main link joins both ends; second link is driven by the bench
   qsfls_link_if lk ();
   qsfls_link_if lk2 ();

   qsfls_host qsfls_host_inst (.clk(clk), .reset(reset), .link(lk.host),
      .start(start), .dir(hdir), .tx_lane0(h0), .tx_lane2(h2),
      .tx_lane3(h3), .rx_lane2(hrx2), .rx_lane3(hrx3), .busy(busy),
      .done(done));
   qsfls_device qsfls_device_inst (.clk(clk), .reset(reset),
      .link(lk.device), .dir(ddir), .tx_lane2(d2), .tx_lane3(d3),
      .rx_lane2(drx2), .rx_lane3(drx3), .rx_lane0(drx0),
      .rx_valid(rx_valid), .armed(armed));
   // second device: its select is held low from power-up until t_unarmed raises it
   qsfls_device qsfls_device_inst_b (.clk(clk), .reset(reset),
      .link(lk2.device), .dir(qsfls_pkg::QSFLS_READ), .tx_lane2(8'h5a),
      .tx_lane3(8'h5a), .rx_lane2(), .rx_lane3(), .rx_lane0(),
      .rx_valid(dv2_valid), .armed(dv2_armed));
   qsfls_props qsfls_props_inst (.clk(clk), .reset(reset),
      .serial_clock_in(lk.serial_clock_in),
      .chip_select_n(lk.chip_select_n), .lane2(lk.lane2), .lane3(lk.lane3),
      .lane2_dev_o(lk.lane2_dev_o), .lane2_dev_oe(lk.lane2_dev_oe),
      .lane3_dev_o(lk.lane3_dev_o), .lane3_dev_oe(lk.lane3_dev_oe),
      .lane2_host_o(lk.lane2_host_o), .lane2_host_oe(lk.lane2_host_oe),
      .lane3_host_oe(lk.lane3_host_oe));

   // 20 mhz system clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // any sign of life from the unarmed device is remembered
   always @(posedge clk) begin
      if (reset) begin
         bad2 <= 1'b0;
      end else if (dv2_valid === 1'b1 || lk2.lane2_dev_oe === 1'b1) begin
         bad2 <= 1'b1;
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   // one whole frame; device sends the inverse of the host pattern
   task automatic run_frame(input qsfls_pkg::qsfls_dir_type d,
                            input logic [7:0] a, b, c);
      int i;
      @(negedge clk);
      hdir = d;
      ddir = d;
      h0 = a;
      h2 = b;
      h3 = c;
      d2 = ~b;
      d3 = ~c;
      start = 1'b1;
      {r0, r2, r3} = 'x;
      hi = 1'b1;
      @(negedge clk);
      start = 1'b0;
      // bounded wait; a frame is about 80 clocks
      for (i = 0; i < 400 && done !== 1'b1; i++) begin
         @(negedge clk);
         if (lk.lane2 !== 1'b1 || lk.lane3 !== 1'b1) hi = 1'b0;
         if (rx_valid === 1'b1) {r0, r2, r3} = {drx0, drx2, drx3};
      end
      chk({7'h00, done}, 8'h01);
      chk(r0, a);
      case (d)
         qsfls_pkg::QSFLS_WRITE: begin
            chk(r2, b);
            chk(r3, c);
         end
         qsfls_pkg::QSFLS_READ: begin
            chk(hrx2, ~b);
            chk(hrx3, ~c);
         end
         default: begin
            chk({7'h00, hi}, 8'h01);
         end
      endcase
   endtask : run_frame

   task automatic t_arm;
      int i;
      for (i = 0; i < 50 && busy !== 1'b0; i++) @(negedge clk);
      chk({7'h00, armed}, 8'h01);
      $display("test arm done");
   endtask : t_arm

   // back to back frames, every lane direction
   task automatic t_modes;
      run_frame(qsfls_pkg::QSFLS_WRITE, 8'ha5, 8'h3c, 8'h81);
      run_frame(qsfls_pkg::QSFLS_READ, 8'h96, 8'h0f, 8'hf0);
      run_frame(qsfls_pkg::QSFLS_IDLE, 8'h7e, 8'h00, 8'hff);
      $display("test modes done");
   endtask : t_modes

   task automatic t_desel;
      run_frame(qsfls_pkg::QSFLS_READ, 8'h01, 8'h80, 8'h01);
      repeat (6) @(negedge clk);
      chk({6'h00, lk.lane2_dev_oe, lk.lane3_dev_oe}, 8'h00);
      chk({6'h00, lk.lane2, lk.lane3}, 8'h03);
      $display("test deselect done");
   endtask : t_desel

   // traffic with select low since power-up must be ignored
   task automatic t_unarmed;
      repeat (8) begin
         repeat (4) @(negedge clk);
         lk2.serial_clock_in = 1'b1;
         repeat (4) @(negedge clk);
         lk2.serial_clock_in = 1'b0;
      end
      chk({7'h00, bad2}, 8'h00);
      chk({7'h00, dv2_armed}, 8'h00);
      repeat (8) @(negedge clk);
      lk2.chip_select_n = 1'b1;
      repeat (8) @(negedge clk);
      lk2.chip_select_n = 1'b0;
      repeat (8) @(negedge clk);
      lk2.chip_select_n = 1'b1;
      repeat (8) @(negedge clk);
      chk({7'h00, dv2_armed}, 8'h01);
      $display("test unarmed done");
   endtask : t_unarmed

   initial begin
      {reset, start} = 2'b10;
      hdir = qsfls_pkg::QSFLS_IDLE;
      ddir = qsfls_pkg::QSFLS_IDLE;
      {h0, h2, h3, d2, d3} = '0;
      {lk2.chip_select_n, lk2.serial_clock_in, lk2.data_lane_zero} = 3'b001;
      {lk2.lane2_host_o, lk2.lane2_host_oe} = 2'b10;
      {lk2.lane3_host_o, lk2.lane3_host_oe} = 2'b10;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      t_arm;
      t_modes;
      t_desel;
      t_unarmed;
      report_and_stop;
   end

   // hang guard, well beyond the few hundred clocks needed
   initial begin
      #200000;
      error_cnt++;
      report_and_stop;
   end
endmodule : qsfls_test

// ---- hw/qsfls_device.sv ----
`timescale 1ns/1ps
module qsfls_device (
   // system
   input  wire logic                    clk,
   input  wire logic                    reset,
   // link
   qsfls_link_if.device                 link,
   // user side
   input  wire qsfls_pkg::qsfls_dir_type dir,
   input  wire logic [7:0]              tx_lane2,
   input  wire logic [7:0]              tx_lane3,
   output logic [7:0]                   rx_lane2,
   output logic [7:0]                   rx_lane3,
   output logic [7:0]                   rx_lane0,
   output logic                         rx_valid,
   output logic                         armed
);
   // three stage samplers for pins from the host domain
   logic [2:0] sclk_s;
   logic [2:0] cs_s;
   logic [2:0] d0_s;
   logic [2:0] l2_s;
   logic [2:0] l3_s;
   logic       sclk_q;               // accepted clock level
   logic       cs_q;                 // accepted select level
   logic [7:0] sh2;                  // outgoing lane 2 bits
   logic [7:0] sh3;
   logic [3:0] bit_cnt;              // bits captured this frame

   // sampler chain; stage 0 is read only by stage 1
   always_ff @(posedge clk) begin
      if (reset) begin
         sclk_s <= 3'h0;
         // select starts low so a pin held low since power-up never
         // looks like a falling edge; it must be seen high first
         cs_s   <= 3'h0;
         d0_s   <= 3'h7;
         l2_s   <= 3'h7;
         l3_s   <= 3'h7;
      end else begin
         sclk_s <= {sclk_s[1:0], link.serial_clock_in};
         cs_s   <= {cs_s[1:0], link.chip_select_n};
         d0_s   <= {d0_s[1:0], link.data_lane_zero};
         l2_s   <= {l2_s[1:0], link.lane2};
         l3_s   <= {l3_s[1:0], link.lane3};
      end
   end

   // a level counts only once stages 1 and 2 agree
   always_ff @(posedge clk) begin
      if (reset) begin
         sclk_q <= 1'b0;
         cs_q   <= 1'b0;
      end else begin
         if (sclk_s[1] == sclk_s[2]) begin
            sclk_q <= sclk_s[2];
         end
         if (cs_s[1] == cs_s[2]) begin
            cs_q <= cs_s[2];
         end
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic active;
   assign sclk_rise = sclk_s[1] && sclk_s[2] && !sclk_q;
   assign sclk_fall = !sclk_s[1] && !sclk_s[2] && sclk_q;
   assign cs_fall   = !cs_s[1] && !cs_s[2] && cs_q;
   // active only while selected and after power-up arming
   assign active    = armed && !cs_q;

   // arming: nothing is answered before the first select fall
   always_ff @(posedge clk) begin
      if (reset) begin
         armed <= 1'b0;
      end else if (cs_fall) begin
         armed <= 1'b1;
      end
   end

   // capture of host data on rising serial clock edges
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_lane0 <= qsfls_pkg::BYTE_ZERO;
         rx_lane2 <= qsfls_pkg::BYTE_ZERO;
         rx_lane3 <= qsfls_pkg::BYTE_ZERO;
         bit_cnt  <= 4'h0;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (cs_q || !armed) begin
            bit_cnt <= 4'h0;
         end else if (sclk_rise) begin
            rx_lane0 <= {rx_lane0[6:0], d0_s[2]};
            if (dir == qsfls_pkg::QSFLS_WRITE) begin
               rx_lane2 <= {rx_lane2[6:0], l2_s[2]};
               rx_lane3 <= {rx_lane3[6:0], l3_s[2]};
            end
            if (bit_cnt == qsfls_pkg::FRAME_BITS - 4'h1) begin
               bit_cnt  <= 4'h0;
               rx_valid <= 1'b1;
            end else begin
               bit_cnt <= bit_cnt + 4'h1;
            end
         end
      end
   end

   // outgoing shifters advance on falling serial clock edges
   always_ff @(posedge clk) begin
      if (reset) begin
         sh2 <= qsfls_pkg::BYTE_ZERO;
         sh3 <= qsfls_pkg::BYTE_ZERO;
         link.lane2_dev_o <= 1'b1;
         link.lane3_dev_o <= 1'b1;
      end else if (!active) begin
         // reload so the first bit is ready at select low
         sh2 <= tx_lane2;
         sh3 <= tx_lane3;
      end else if (sclk_fall && dir == qsfls_pkg::QSFLS_READ) begin
         link.lane2_dev_o <= sh2[7];
         link.lane3_dev_o <= sh3[7];
         sh2 <= {sh2[6:0], 1'b0};
         sh3 <= {sh3[6:0], 1'b0};
      end
   end

   // drivers on only for an active quad read; else high impedance
   always_ff @(posedge clk) begin
      if (reset) begin
         link.lane2_dev_oe <= 1'b0;
         link.lane3_dev_oe <= 1'b0;
      end else begin
         link.lane2_dev_oe <= active && dir == qsfls_pkg::QSFLS_READ;
         link.lane3_dev_oe <= active && dir == qsfls_pkg::QSFLS_READ;
      end
   end
endmodule : qsfls_device

// ---- hw/qsfls_host.sv ----
`timescale 1ns/1ps
module qsfls_host (
   // system
   input  wire logic                    clk,
   input  wire logic                    reset,
   // link
   qsfls_link_if.host                   link,
   // user side
   input  wire logic                    start,
   input  wire qsfls_pkg::qsfls_dir_type dir,
   input  wire logic [7:0]              tx_lane0,
   input  wire logic [7:0]              tx_lane2,
   input  wire logic [7:0]              tx_lane3,
   output logic [7:0]                   rx_lane2,
   output logic [7:0]                   rx_lane3,
   output logic                         busy,
   output logic                         done
);
   typedef enum logic [1:0] {
      QSFLS_H_WAKE = 2'b00, // power-up select pulse
      QSFLS_H_IDLE = 2'b01,
      QSFLS_H_RUN  = 2'b10,
      QSFLS_H_END  = 2'b11
   } qsfls_hstate_type;

   qsfls_hstate_type        state;
   qsfls_pkg::qsfls_dir_type dir_q;   // direction held for the frame
   logic [3:0] div;                   // half period counter
   logic [3:0] bits;                  // rising edges issued
   logic [7:0] sh0;
   logic [7:0] sh2;
   logic [7:0] sh3;
   logic [2:0] l2_s;                  // samplers for device lanes
   logic [2:0] l3_s;
   logic       tick;
   assign tick = (div == qsfls_pkg::SCLK_HALF_CYC - 4'h1);

   // samplers; a 200 ns half period covers the sampler delay
   always_ff @(posedge clk) begin
      if (reset) begin
         l2_s <= 3'h7;
         l3_s <= 3'h7;
      end else begin
         l2_s <= {l2_s[1:0], link.lane2};
         l3_s <= {l3_s[1:0], link.lane3};
      end
   end

   // half period divider, free running in every state but idle
   always_ff @(posedge clk) begin
      if (reset || state == QSFLS_H_IDLE || tick) begin
         div <= 4'h0;
      end else begin
         div <= div + 4'h1;
      end
   end

   // framing, serial clock and data shifting
   always_ff @(posedge clk) begin
      if (reset) begin
         state  <= QSFLS_H_WAKE;
         dir_q  <= qsfls_pkg::QSFLS_IDLE;
         bits   <= 4'h0;
         sh0    <= qsfls_pkg::BYTE_ZERO;
         sh2    <= qsfls_pkg::BYTE_ZERO;
         sh3    <= qsfls_pkg::BYTE_ZERO;
         rx_lane2 <= qsfls_pkg::BYTE_ZERO;
         rx_lane3 <= qsfls_pkg::BYTE_ZERO;
         busy   <= 1'b1;
         done   <= 1'b0;
         link.chip_select_n   <= 1'b1;
         link.serial_clock_in <= 1'b0;
         link.data_lane_zero  <= 1'b1;
         link.lane2_host_o    <= 1'b1;
         link.lane3_host_o    <= 1'b1;
         link.lane2_host_oe   <= 1'b1;
         link.lane3_host_oe   <= 1'b1;
      end else begin
         done <= 1'b0;
         case (state)
            QSFLS_H_WAKE: begin
               // one select fall before any operation
               if (tick) begin
                  link.chip_select_n <= !link.chip_select_n;
                  if (!link.chip_select_n) begin
                     state <= QSFLS_H_IDLE;
                     busy  <= 1'b0;
                  end
               end
            end
            QSFLS_H_IDLE: begin
               if (start) begin
                  dir_q <= dir;
                  sh0   <= tx_lane0;
                  sh2   <= tx_lane2;
                  sh3   <= tx_lane3;
                  bits  <= 4'h0;
                  busy  <= 1'b1;
                  link.chip_select_n  <= 1'b0;
                  link.data_lane_zero <= tx_lane0[7];
                  // drive data only for quad write; hold high for idle, release for read
                  link.lane2_host_o  <= (dir == qsfls_pkg::QSFLS_WRITE)
                                        ? tx_lane2[7] : 1'b1;
                  link.lane3_host_o  <= (dir == qsfls_pkg::QSFLS_WRITE)
                                        ? tx_lane3[7] : 1'b1;
                  link.lane2_host_oe <= dir != qsfls_pkg::QSFLS_READ;
                  link.lane3_host_oe <= dir != qsfls_pkg::QSFLS_READ;
                  state <= QSFLS_H_RUN;
               end
            end
            QSFLS_H_RUN: begin
               if (tick) begin
                  link.serial_clock_in <= !link.serial_clock_in;
                  if (!link.serial_clock_in) begin
                     bits <= bits + 4'h1;
                  end else begin
                     // falling edge: take device bit, present next
                     rx_lane2 <= {rx_lane2[6:0], l2_s[2]};
                     rx_lane3 <= {rx_lane3[6:0], l3_s[2]};
                     sh0 <= {sh0[6:0], 1'b1};
                     link.data_lane_zero <= sh0[6];
                     if (dir_q == qsfls_pkg::QSFLS_WRITE) begin
                        sh2 <= {sh2[6:0], 1'b1};
                        sh3 <= {sh3[6:0], 1'b1};
                        link.lane2_host_o <= sh2[6];
                        link.lane3_host_o <= sh3[6];
                     end
                     // read data lags one fall: a ninth rising edge lets
                     // the last device bit be taken on the closing fall
                     if (bits == qsfls_pkg::FRAME_BITS + 4'h1) begin
                        state <= QSFLS_H_END;
                     end
                  end
               end
            end
            QSFLS_H_END: begin
               // close the frame, then wait for the device samplers to
               // drop its drivers before taking the lanes back high
               if (tick) begin
                  link.chip_select_n <= 1'b1;
                  bits <= bits + 4'h1;
                  if (bits == qsfls_pkg::FRAME_BITS + 4'h3) begin
                     link.lane2_host_o  <= 1'b1;
                     link.lane3_host_o  <= 1'b1;
                     link.lane2_host_oe <= 1'b1;
                     link.lane3_host_oe <= 1'b1;
                     busy  <= 1'b0;
                     done  <= 1'b1;
                     state <= QSFLS_H_IDLE;
                  end
               end
            end
            default: state <= QSFLS_H_IDLE;
         endcase
      end
   end
endmodule : qsfls_host

// ---- hw/qsfls_link_if.sv ----
`timescale 1ns/1ps
interface qsfls_link_if;
   logic serial_clock_in;     // host made serial clock
   logic chip_select_n;       // active low frame select
   logic data_lane_zero;      // host to device, single lane data
   logic lane2_dev_o;         // device drive value, lane 2
   logic lane2_dev_oe;        // device drives lane 2
   logic lane3_dev_o;
   logic lane3_dev_oe;
   logic lane2_host_o;        // host drive value, lane 2
   logic lane2_host_oe;
   logic lane3_host_o;
   logic lane3_host_oe;
   // resolved wire levels; undriven lanes pull up to the supply
   wire  lane2 = lane2_dev_oe ? lane2_dev_o :
                 (lane2_host_oe ? lane2_host_o : 1'b1);
   wire  lane3 = lane3_dev_oe ? lane3_dev_o :
                 (lane3_host_oe ? lane3_host_o : 1'b1);

   modport device (
      input  serial_clock_in, chip_select_n, data_lane_zero, lane2, lane3,
      output lane2_dev_o, lane2_dev_oe, lane3_dev_o, lane3_dev_oe
   );
   modport host (
      input  lane2, lane3,
      output serial_clock_in, chip_select_n, data_lane_zero,
             lane2_host_o, lane2_host_oe, lane3_host_o, lane3_host_oe
   );
endinterface : qsfls_link_if

// ---- hw/qsfls_pkg.sv ----
package qsfls_pkg;
   // lane direction per transfer, chosen by the host and device user sides
   typedef enum logic [1:0] {
      QSFLS_IDLE  = 2'b00, // lanes 2 and 3 unused (single or dual lane)
      QSFLS_WRITE = 2'b01, // quad write: host drives lanes 2 and 3
      QSFLS_READ  = 2'b10  // quad read or configuration: device drives
   } qsfls_dir_type;

   // host serial clock divider: half period in system clocks
   localparam int unsigned SYS_CLK_NS    = 50;
   localparam int unsigned SCLK_HALF_NS  = 200;
   localparam logic [3:0]  SCLK_HALF_CYC =
      4'((SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
   // bits carried per lane per frame
   localparam logic [3:0]  FRAME_BITS    = 4'h8;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
endpackage : qsfls_pkg
